// ---- logic/uis_pkg.sv ----
package uis_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_RAW = 8'h00;
    localparam logic [7:0] OFS_MASKED = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_CONFIG = 8'h10;
    localparam logic [7:0] OFS_RXERR = 8'h14;
    localparam logic [7:0] OFS_TXSTAT = 8'h18;
    // interrupt source positions
    localparam int IRQ_COUNT = 12;
    localparam int BIT_MODEM_RING = 0;
    localparam int BIT_MODEM_CTS = 1;
    localparam int BIT_MODEM_DCD = 2;
    localparam int BIT_MODEM_DSR = 3;
    localparam int BIT_RX = 4;
    localparam int BIT_TX = 5;
    localparam int BIT_RX_TIMEOUT = 6;
    localparam int BIT_FRAMING_ERR = 7;
    localparam int BIT_PARITY_ERR = 8;
    localparam int BIT_BREAK = 9;
    localparam int BIT_OVERRUN = 10;
    localparam int BIT_ADDR_MATCH = 11;
    // receive error word positions
    localparam int ERR_FRAMING = 0;
    localparam int ERR_PARITY = 1;
    localparam int ERR_BREAK = 2;
    localparam int ERR_OVERRUN = 3;
    // config field positions
    localparam int CFG_PARITY_LSB = 0;
    localparam int CFG_TXMODE = 4;
    localparam int CFG_TXLVL_LSB = 8;
    localparam int CFG_RXLVL_LSB = 12;
    localparam int CFG_ERRCLR = 16;
    localparam logic [2:0] LVL_1_8 = 3'h0;
    localparam logic [2:0] LVL_2_8 = 3'h1;
    localparam logic [2:0] LVL_4_8 = 3'h2;
    localparam logic [2:0] LVL_6_8 = 3'h3;
    localparam logic [2:0] LVL_7_8 = 3'h4;
    localparam logic [2:0] LVL_RESET = LVL_4_8;
    // fifo depth in characters
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    typedef enum logic [2:0] {
        parity_off = 3'h0,
        parity_even_sel = 3'h1,
        parity_odd_sel = 3'h2,
        parity_stuck_high = 3'h3,
        parity_stuck_low = 3'h4
    } uis_parity_type;
    typedef enum logic {
        tx_irq_on_level = 1'b0,
        tx_irq_on_idle = 1'b1
    } uis_txmode_type;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uis_pkg

// ---- logic/uis_cfg_if.sv ----
`timescale 1ns/1ps
interface uis_cfg_if;
    import uis_pkg::*;
    logic [2:0] parity;
    logic [2:0] txLevel;
    logic [2:0] rxLevel;
    logic [4:0] txFill;
    logic [4:0] rxFill;
    logic txIdle;
    logic txBelow;
    logic rxAbove;
    modport ctrl (output parity, output txLevel, output rxLevel,
        output txFill, output rxFill, input txIdle, input txBelow,
        input rxAbove);
    modport eval (input parity, input txLevel, input rxLevel,
        input txFill, input rxFill, output txIdle, output txBelow,
        output rxAbove);
endinterface : uis_cfg_if

// ---- logic/uis_level_eval.sv ----
`timescale 1ns/1ps
module uis_level_eval
    import uis_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic srst,
    // configuration and fill levels
    uis_cfg_if.eval cfg,
    // transmitter state
    input wire logic shifterBusy
);
    function automatic logic [4:0] mark(input logic [2:0] sel);
        case (sel)
            LVL_1_8: mark = FIFO_DEPTH >> 3;
            LVL_2_8: mark = FIFO_DEPTH >> 2;
            LVL_6_8: mark = (FIFO_DEPTH >> 1) + (FIFO_DEPTH >> 2);
            LVL_7_8: mark = FIFO_DEPTH - (FIFO_DEPTH >> 3);
            default: mark = FIFO_DEPTH >> 1;
        endcase
    endfunction : mark

    always_ff @(posedge clock) begin
        if (srst) begin
            cfg.txBelow <= 1'b0;
            cfg.rxAbove <= 1'b0;
            cfg.txIdle <= 1'b0;
        end else begin
            cfg.txBelow <= cfg.txFill <= mark(cfg.txLevel);
            cfg.rxAbove <= cfg.rxFill >= mark(cfg.rxLevel);
            // empty fifo and stop bits gone
            cfg.txIdle <= (cfg.txFill == 5'h00) && !shifterBusy;
        end
    end
endmodule : uis_level_eval

// ---- logic/uis_parity_unit.sv ----
`timescale 1ns/1ps
module uis_parity_unit
    import uis_pkg::*;
(
    // selection
    input wire logic [2:0] parity,
    // transmit side
    input wire logic [7:0] txData,
    output logic txParityBit,
    output logic txParityOn,
    // receive side
    input wire logic [7:0] rxData,
    input wire logic rxParityBit,
    output logic rxParityBad
);
    function automatic logic pbit(input logic [2:0] sel,
        input logic [7:0] d);
        case (sel)
            parity_even_sel: pbit = ^d;
            parity_odd_sel: pbit = ~^d;
            parity_stuck_high: pbit = 1'b1;
            parity_stuck_low: pbit = 1'b0;
            default: pbit = 1'b0;
        endcase
    endfunction : pbit

    always_comb begin
        txParityOn = parity != parity_off;
        txParityBit = pbit(parity, txData);
        rxParityBad = txParityOn
            && (pbit(parity, rxData) != rxParityBit);
    end
endmodule : uis_parity_unit

// ---- logic/uart_irq_error_parity_status.sv ----
// Behaviour
// - writing ones to the clear register drops only those pending sources
// - each source has an enable; disabled sources never reach the interrupt
// - twelve sources: address match, errors, timeout, tx, rx, four modem
// - status readable raw or masked by the enables
// - parity choice: none, even, odd, stuck one, stuck zero
// - parity applies to transmit and receive and reads back
// - four receive error flags read together as one word
// - overrun flag sets at once when overrun happens
// - one write clears all receive error flags
// - status bit shows transmit fifo has room for a character
// - idle mode: tx interrupt when fifo empty and shifter done
// - level mode: tx interrupt from fifo fill versus threshold
// - transmit interrupt mode is a readable setting
// - tx and rx thresholds of 1/8,2/8,4/8,6/8,7/8, readable
// - after reset the tx interrupt runs in level mode
`timescale 1ns/1ps
module uart_irq_error_parity_status
    import uis_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic srst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // receiver events, one-cycle pulses
    input wire logic evAddrMatch,
    input wire logic evOverrun,
    input wire logic evBreak,
    input wire logic evParityErr,
    input wire logic evFramingErr,
    input wire logic evRxTimeout,
    // receive character for parity checking
    input wire logic rxCharValid,
    input wire logic [7:0] rxChar,
    input wire logic rxCharParity,
    // modem line levels from pins
    input wire logic modemDsr,
    input wire logic modemDcd,
    input wire logic modemCts,
    input wire logic modemRing,
    // fifo fill levels and transmit path state
    input wire logic [4:0] txFill,
    input wire logic [4:0] rxFill,
    input wire logic txShifterBusy,
    input wire logic [7:0] txChar,
    // outputs
    output logic txParityBit,
    output logic txParityOn,
    output logic txSpaceAvail,
    output logic irq
);
    uis_cfg_if cfg();

    logic [IRQ_COUNT-1:0] rawStatus;
    logic [IRQ_COUNT-1:0] enable;
    logic [3:0] rxErr;
    logic [2:0] parityCfg;
    logic txMode;
    logic [2:0] txLevelCfg;
    logic [2:0] rxLevelCfg;
    logic [3:0] modemSync1;
    logic [3:0] modemSync2;
    logic [3:0] modemLast;
    logic [1:0] modemWarm;
    logic modemArmed;
    logic rxParityBad;
    logic nextTxParityBit;
    logic nextTxParityOn;
    logic txBelowLast;
    logic txIdleLast;
    logic rxAboveLast;

    // write channel capture
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic [IRQ_COUNT-1:0] clearMask;
    logic errClear;
    logic [IRQ_COUNT-1:0] events;

    assign cfg.parity = parityCfg;
    assign cfg.txLevel = txLevelCfg;
    assign cfg.rxLevel = rxLevelCfg;
    assign cfg.txFill = txFill;
    assign cfg.rxFill = rxFill;

    uis_level_eval levels (
        .clock(clock),
        .srst(srst),
        .cfg(cfg),
        .shifterBusy(txShifterBusy)
    );

    uis_parity_unit parity (
        .parity(parityCfg),
        .txData(txChar),
        .txParityBit(nextTxParityBit),
        .txParityOn(nextTxParityOn),
        .rxData(rxChar),
        .rxParityBit(rxCharParity),
        .rxParityBad(rxParityBad)
    );

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // axi write side
    always_ff @(posedge clock) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awAddr)
                    OFS_ENABLE, OFS_CLEAR, OFS_CONFIG:
                        s_axi_bresp <= RESP_OKAY;
                    OFS_RAW, OFS_MASKED, OFS_RXERR, OFS_TXSTAT:
                        s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        clearMask = '0;
        errClear = 1'b0;
        if (doWrite && awAddr == OFS_CLEAR) begin
            clearMask[7:0] = wStrb[0] ? wData[7:0] : 8'h00;
            clearMask[11:8] = wStrb[1] ? wData[11:8] : 4'h0;
        end
        if (doWrite && awAddr == OFS_CONFIG && wStrb[2]) begin
            errClear = wData[CFG_ERRCLR];
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (srst) begin
            enable <= '0;
            parityCfg <= parity_off;
            txMode <= tx_irq_on_level;
            txLevelCfg <= LVL_RESET;
            rxLevelCfg <= LVL_RESET;
        end else if (doWrite && awAddr == OFS_ENABLE) begin
            if (wStrb[0]) enable[7:0] <= wData[7:0];
            if (wStrb[1]) enable[11:8] <= wData[11:8];
        end else if (doWrite && awAddr == OFS_CONFIG) begin
            if (wStrb[0] && wData[2:0] <= parity_stuck_low) begin
                parityCfg <= wData[2:0];
            end
            if (wStrb[0]) txMode <= wData[CFG_TXMODE];
            if (wStrb[1] && wData[10:8] <= LVL_7_8) begin
                txLevelCfg <= wData[10:8];
            end
            if (wStrb[1] && wData[14:12] <= LVL_7_8) begin
                rxLevelCfg <= wData[14:12];
            end
        end
    end

    // modem pin synchronisers and tx/rx level history
    always_ff @(posedge clock) begin
        if (srst) begin
            modemSync1 <= 4'h0;
            modemSync2 <= 4'h0;
            modemLast <= 4'h0;
            modemWarm <= 2'h0;
            txBelowLast <= 1'b0;
            txIdleLast <= 1'b0;
            rxAboveLast <= 1'b0;
        end else begin
            modemSync1 <= {modemDsr, modemDcd, modemCts, modemRing};
            modemSync2 <= modemSync1;
            modemLast <= modemSync2;
            if (modemWarm != 2'h3) modemWarm <= modemWarm + 2'h1;
            txBelowLast <= cfg.txBelow;
            txIdleLast <= cfg.txIdle;
            rxAboveLast <= cfg.rxAbove;
        end
    end

    always_comb begin
        events = '0;
        events[BIT_ADDR_MATCH] = evAddrMatch;
        events[BIT_OVERRUN] = evOverrun;
        events[BIT_BREAK] = evBreak;
        events[BIT_PARITY_ERR] = evParityErr || (rxCharValid && rxParityBad);
        events[BIT_FRAMING_ERR] = evFramingErr;
        events[BIT_RX_TIMEOUT] = evRxTimeout;
        if (txMode == tx_irq_on_idle) begin
            events[BIT_TX] = cfg.txIdle && !txIdleLast;
        end else begin
            events[BIT_TX] = cfg.txBelow && !txBelowLast;
        end
        events[BIT_RX] = cfg.rxAbove && !rxAboveLast;
        events[BIT_MODEM_DSR] = modemArmed && (modemSync2[3] ^ modemLast[3]);
        events[BIT_MODEM_DCD] = modemArmed && (modemSync2[2] ^ modemLast[2]);
        events[BIT_MODEM_CTS] = modemArmed && (modemSync2[1] ^ modemLast[1]);
        events[BIT_MODEM_RING] = modemArmed && (modemSync2[0] ^ modemLast[0]);
    end

    // no false pin edge while the chain still holds reset zeros
    assign modemArmed = modemWarm == 2'h3;

    // sticky status, set wins over clear
    genvar i;
    generate
        for (i = 0; i < IRQ_COUNT; i++) begin : g_status
            always_ff @(posedge clock) begin
                if (srst) begin
                    rawStatus[i] <= 1'b0;
                end else if (events[i]) begin
                    rawStatus[i] <= 1'b1;
                end else if (clearMask[i]) begin
                    rawStatus[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // receive error flags
    always_ff @(posedge clock) begin
        if (srst) begin
            rxErr <= 4'h0;
        end else begin
            rxErr[ERR_OVERRUN] <= evOverrun
                || (rxErr[ERR_OVERRUN] && !errClear);
            rxErr[ERR_FRAMING] <= (rxCharValid && evFramingErr)
                || (rxErr[ERR_FRAMING] && !errClear);
            rxErr[ERR_PARITY] <= events[BIT_PARITY_ERR]
                || (rxErr[ERR_PARITY] && !errClear);
            rxErr[ERR_BREAK] <= evBreak
                || (rxErr[ERR_BREAK] && !errClear);
        end
    end

    // outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            irq <= 1'b0;
            txSpaceAvail <= 1'b0;
            txParityBit <= 1'b0;
            txParityOn <= 1'b0;
        end else begin
            irq <= |(rawStatus & enable);
            txSpaceAvail <= txFill < FIFO_DEPTH;
            txParityBit <= nextTxParityBit;
            txParityOn <= nextTxParityOn;
        end
    end

    // axi read side
    always_ff @(posedge clock) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0;
                case (s_axi_araddr)
                    OFS_RAW: s_axi_rdata[11:0] <= rawStatus;
                    OFS_MASKED: s_axi_rdata[11:0] <= rawStatus & enable;
                    OFS_ENABLE: s_axi_rdata[11:0] <= enable;
                    OFS_CLEAR: s_axi_rdata <= 32'h0;
                    OFS_CONFIG: s_axi_rdata <= {15'h0, 1'b0, 1'b0,
                        rxLevelCfg, 1'b0, txLevelCfg, 3'h0, txMode,
                        1'b0, parityCfg};
                    OFS_RXERR: s_axi_rdata[3:0] <= rxErr;
                    OFS_TXSTAT: s_axi_rdata[1:0] <= {cfg.txIdle,
                        txSpaceAvail};
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : uart_irq_error_parity_status

// ---- sim/uis_checker.sv ----
`timescale 1ns/1ps
module uis_checker
    import uis_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic srst,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status
    input wire logic [4:0] txFill,
    input wire logic txSpaceAvail,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    space_flag_a: assert property (!$past(srst) |->
        txSpaceAvail == ($past(txFill) < FIFO_DEPTH))
        else $error("space flag");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read late");
    write_answer_a: assert property ($rose(s_axi_awvalid) |->
        ##[2:8] s_axi_bvalid) else $error("write late");
    slverr_zero_a: assert property (s_axi_rvalid &&
        s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("slverr data");
    read_single_a: assert property (s_axi_rvalid |->
        !s_axi_arready) else $error("second read");
    reset_quiet_a: assert property (@(posedge clock) disable iff (1'b0)
        srst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("reset outputs");
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property ($fell(txSpaceAvail));
endmodule : uis_checker
bind uart_irq_error_parity_status uis_checker uis_checker_inst (.*);

// ---- sim/uis_remote.sv ----
`timescale 1ns/1ps
module uis_remote
    import uis_pkg::*;
(
    // clocking
    input wire logic clock,
    // received character
    output logic rxCharValid,
    output logic [7:0] rxChar,
    output logic rxCharParity,
    // line events and modem pins
    output logic [11:0] src
);
    initial begin
        rxCharValid = 1'b0;
        rxChar = 8'h00;
        rxCharParity = 1'b0;
        src = 12'h000;
    end
    function automatic logic par(input logic [2:0] m, input logic [7:0] d);
        case (m)
            parity_even_sel: return ^d;
            parity_odd_sel: return ~^d;
            parity_stuck_high: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : par
    // below 4 toggles a modem pin, above 5 pulses an event with a char
    task automatic hit(input int i, input logic [2:0] m, input logic bad,
        input logic [7:0] d);
        @(posedge clock);
        if (i < 4) begin
            src[i] <= ~src[i];
        end else begin
            rxChar <= d;
            rxCharParity <= par(m, d) ^ bad;
            rxCharValid <= 1'b1;
            src[i] <= (i > 5);
            @(posedge clock);
            rxCharValid <= 1'b0;
            src[i] <= 1'b0;
            rxChar <= ~d;
        end
    endtask : hit
endmodule : uis_remote

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import uis_pkg::*;
;
    logic clock = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, txChar = 0, d;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, cfg;
    logic [4:0] txFill = 5'h10, rxFill = 0, mk;
    logic txShifterBusy = 0, rxCharValid, rxCharParity;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, txParityBit, txParityOn, txSpaceAvail, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] rxChar;
    logic [11:0] src, raw, en, c;
    logic [3:0] err;
    logic [33:0] expq[$];
    string nq[$];
    int tests_run = 0, mismatches = 0, seed = 32'h36af927f, i, m;
    initial forever #5 clock = ~clock;
    uart_irq_error_parity_status uart_irq_error_parity_status_inst (
        .clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .evAddrMatch(src[11]),
        .evOverrun(src[10]), .evBreak(src[9]), .evParityErr(src[8]),
        .evFramingErr(src[7]), .evRxTimeout(src[6]), .rxCharValid,
        .rxChar, .rxCharParity, .modemDsr(src[3]), .modemDcd(src[2]),
        .modemCts(src[1]), .modemRing(src[0]), .txFill, .rxFill,
        .txShifterBusy, .txChar, .txParityBit, .txParityOn, .txSpaceAvail,
        .irq);
    uis_remote uis_remote_inst (.clock, .rxCharValid, .rxChar,
        .rxCharParity, .src);
    task automatic chk(input string n, input logic [33:0] e,
        input logic [33:0] v);
        tests_run++;
        if (v !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] r = RESP_OKAY);
        expq.push_back({r, 32'h0});
        nq.push_back("bresp");
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        fork
            begin do @(posedge clock); while (!s_axi_awready);
                s_axi_awvalid <= 0; end
            begin do @(posedge clock); while (!s_axi_wready);
                s_axi_wvalid <= 0; end
        join
        // bready stays up, only a write raises bvalid
        do @(posedge clock); while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
        input string n, input logic [1:0] r = RESP_OKAY);
        expq.push_back({r, v});
        nq.push_back(n);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        // rready stays up, only a read raises rvalid
        do @(posedge clock); while (!s_axi_rvalid);
    endtask : rd
    // scoreboard side: each handshake takes the oldest note
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready)
            chk(nq.pop_front(), expq.pop_front(),
                {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk(nq.pop_front(), expq.pop_front(),
                {s_axi_bresp, 32'h0});
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end
    initial begin
        raw = 0;
        err = 0;
        repeat (5) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        rd(OFS_CONFIG, 32'h2200, "config");
        rd(OFS_ENABLE, 0, "enable");
        rd(OFS_RAW, 0, "raw");
        rd(8'h40, 0, "unmapped", RESP_SLVERR);
        rd(OFS_CLEAR, 0, "clear");
        wr(8'h40, 32'hfff, RESP_SLVERR);
        for (i = 0; i < 12; i++) if (i != 4 && i != 5) begin
            uis_remote_inst.hit(i, parity_off, 0, 8'($random(seed)));
            repeat (5) @(posedge clock);
            raw[i] = 1;
            if (i > 6 && i < 11) err[i - 7] = 1;
            rd(OFS_RAW, 32'(raw), "raw");
            rd(OFS_RXERR, 32'(err), "rxerr");
        end
        for (i = 0; i < 4; i++) begin
            en = 12'($random(seed));
            wr(OFS_ENABLE, 32'(en));
            rd(OFS_ENABLE, 32'(en), "enable");
            rd(OFS_MASKED, 32'(raw & en), "masked");
            repeat (2) @(posedge clock);
            chk("irq", 34'(|(raw & en)), 34'(irq));
        end
        c = 12'($random(seed));
        wr(OFS_CLEAR, 32'(c));
        raw = raw & ~c;
        rd(OFS_RAW, 32'(raw), "raw");
        wr(OFS_CONFIG, 32'h12200);
        rd(OFS_RXERR, 0, "rxerr");
        wr(OFS_CLEAR, 32'hfff);
        repeat (2) @(posedge clock);
        chk("irq", 0, 34'(irq));
        for (m = 0; m < 5; m++) begin
            cfg = 32'h2200 | 32'(m) | 32'(m % 2) << 4;
            wr(OFS_CONFIG, cfg);
            rd(OFS_CONFIG, cfg, "config");
            d = 8'($random(seed));
            txChar <= d;
            repeat (3) @(posedge clock);
            chk("par on", 34'(m != 0), 34'(txParityOn));
            if (m != 0)
                chk("par bit", 34'(uis_remote_inst.par(3'(m), d)),
                    34'(txParityBit));
            uis_remote_inst.hit(4, 3'(m), 1, d);
            repeat (3) @(posedge clock);
            rd(OFS_RAW, (m != 0) ? 32'h100 : 0, "raw");
            rd(OFS_RXERR, (m != 0) ? 32'h2 : 0, "rxerr");
            wr(OFS_CLEAR, 32'hfff);
            wr(OFS_CONFIG, cfg | 32'h10000);
        end
        wr(OFS_CONFIG, 32'h2205);
        rd(OFS_CONFIG, 32'h2204, "config");
        for (i = 0; i < 5; i++) begin
            mk = (i == 0) ? 5'h2 : (i == 4) ? 5'he : 5'(4 * i);
            txFill <= 5'h10;
            wr(OFS_CONFIG, 32'h2000 | 32'(i) << 8);
            wr(OFS_CLEAR, 32'h20);
            txFill <= mk + 5'h1;
            repeat (3) @(posedge clock);
            rd(OFS_RAW, 0, "raw");
            txFill <= mk;
            repeat (3) @(posedge clock);
            rd(OFS_RAW, 32'h20, "raw");
            rd(OFS_TXSTAT, 32'h1, "txstat");
            rd(OFS_CONFIG, 32'h2000 | 32'(i) << 8, "config");
        end
        wr(OFS_CONFIG, 32'h2210);
        txShifterBusy <= 1;
        txFill <= 0;
        wr(OFS_CLEAR, 32'h20);
        repeat (4) @(posedge clock);
        rd(OFS_RAW, 0, "raw");
        txShifterBusy <= 0;
        rxFill <= 5'h8;
        repeat (4) @(posedge clock);
        rd(OFS_RAW, 32'h30, "raw");
        rd(OFS_TXSTAT, 32'h3, "txstat");
        repeat (2) @(posedge clock);
        stop_test();
    end
endmodule : testbench
